// ===== inc/sadb_pkg.sv
package sadb_pkg;

	// register indices as printed; byte address is four times the index
	localparam logic [9:0]  REG_PARITY_IDX   = 10'h007;
	localparam logic [9:0]  REG_EDGE_IDX     = 10'h01E;
	localparam logic [9:0]  REG_STATUS_IDX   = 10'h020;
	localparam logic [9:0]  REG_SLOT_IDX     = 10'h021;

	// parity control register fields
	localparam int unsigned PAR_POL_BIT      = 2;
	localparam int unsigned PAR_SCOPE_BIT    = 3;

	// edge control register fields
	localparam int unsigned ADD_DLY_BIT      = 3;
	localparam int unsigned DROP_EDGE_BIT    = 4;
	localparam int unsigned ADD_EDGE_BIT     = 5;

	// status register fields
	localparam int unsigned ST_PAR_ERR_BIT   = 0;
	localparam int unsigned ST_FAIL_BIT      = 1;
	localparam int unsigned ST_CFG_BIT       = 2;
	localparam int unsigned ST_AIS_LSB       = 8;

	// slot control register fields
	localparam int unsigned SLOT_EN_LSB      = 0;
	localparam int unsigned SLOT_BASE_LSB    = 8;

	// reset values
	localparam logic [6:0]  TRIB_EN_RST      = 7'h00;
	localparam logic [6:0]  SLOT_BASE_RST    = 7'h00;

	// bus geometry
	localparam int unsigned NUM_TRIB         = 7;
	localparam logic [6:0]  SLOTS_NARROW     = 7'd28;
	localparam logic [6:0]  SLOTS_WIDE       = 7'd84;
	localparam logic [7:0]  AIS_BYTE         = 8'hFF;

endpackage

// ===== src/sadb_sync.sv
`timescale 1ns/1ps

// two-stage synchroniser; only the second stage leaves the module
module sadb_sync
	import sadb_pkg::*;
#(
	parameter int W = 1
)
(
	// clock and control
	input  wire logic         i_clk_sys,
	input  wire logic         i_sys_rst,
	input  wire logic         i_clk_en,
	// async in, synced out
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);

	typedef struct packed
	{
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sadb_sync_t;

	sadb_sync_t q;
	sadb_sync_t d;

	always_comb
	begin
		d = q;
		if (i_clk_en)
		begin
			d.s1 = i_async;
			d.s2 = q.s1;
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
			q <= '0;
		else
			q <= d;
	end

	assign o_sync = q.s2;

endmodule

// ===== src/sadb_port.sv
`timescale 1ns/1ps

module sadb_port
	import sadb_pkg::*;
#(
	parameter int APB_AW = 12
)
(
	// system clock, reset, enable
	input  wire logic              i_clk_sys,
	input  wire logic              i_sys_rst,
	input  wire logic              i_clk_en,
	// apb slave
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [APB_AW-1:0] i_paddr,
	input  wire logic [31:0]       i_pwdata,
	output logic      [31:0]       o_prdata,
	output logic                   o_pready,
	output logic                   o_pslverr,
	// bus configuration
	input  wire logic              i_bus_config_pin,
	// drop bus pins
	input  wire logic              i_drop_bus_clock,
	input  wire logic [7:0]        i_drop_byte,
	input  wire logic              i_drop_parity,
	input  wire logic              i_drop_payload_envelope,
	input  wire logic              i_drop_frame_marker,
	input  wire logic              i_drop_signal_fail,
	// add bus pins
	input  wire logic              i_add_bus_clock,
	input  wire logic              i_add_payload_envelope,
	input  wire logic              i_add_frame_marker,
	input  wire logic              i_add_output_enable,
	output logic      [7:0]        o_add_byte,
	output logic                   o_add_byte_oe,
	output logic                   o_add_parity,
	output logic                   o_add_parity_oe,
	output logic                   o_add_present_indicator_n,
	// mapper side, drop direction
	output logic                   o_drop_valid,
	output logic      [7:0]        o_drop_data,
	output logic      [6:0]        o_drop_slot,
	output logic                   o_drop_invalid,
	output logic      [6:0]        o_trib_ais,
	// mapper side, add direction
	input  wire logic [7:0]        i_add_data,
	output logic      [6:0]        o_add_slot
);

	typedef struct packed
	{
		logic        apb_rdy;
		logic [31:0] rdata;
		logic        slverr;
		logic        par_pol;
		logic        par_scope;
		logic        add_dly;
		logic        drop_edge;
		logic        add_edge;
		logic [6:0]  trib_en;
		logic [6:0]  slot_base;
		logic        par_err;
		logic        fail_seen;
		logic        drop_bus_clock_prev;
		logic        aclk_prev;
		logic [6:0]  dslot;
		logic        dvalid;
		logic [7:0]  ddata;
		logic        dinvalid;
		logic [6:0]  ais;
		logic [6:0]  aslot;
		logic        add_payload_envelope;
		logic        amk;
		logic        aown;
		logic [7:0]  st_byte;
		logic        st_par;
		logic        st_drv;
		logic [7:0]  obyte;
		logic        opar;
		logic        odrv;
	} sadb_state_t;

	sadb_state_t q;
	sadb_state_t n;

	logic [17:0] pin_s;
	logic        drop_bus_clock_s;
	logic [7:0]  dbyte_s;
	logic        drop_parity_s;
	logic        drop_payload_envelope_s;
	logic        dmk_s;
	logic        drop_signal_fail_s;
	logic        aclk_s;
	logic        add_payload_envelope_s;
	logic        amk_s;
	logic        aen_s;
	logic        cfg_s;

	// every pin shares one synchroniser so data stays aligned with its clock
	sadb_sync #(.W(18)) u_sync
	(
		.i_clk_sys (i_clk_sys),
		.i_sys_rst (i_sys_rst),
		.i_clk_en  (i_clk_en),
		.i_async   ({i_bus_config_pin, i_add_output_enable,
		              i_add_frame_marker, i_add_payload_envelope,
		              i_add_bus_clock, i_drop_signal_fail,
		              i_drop_frame_marker, i_drop_payload_envelope,
		              i_drop_parity, i_drop_byte, i_drop_bus_clock}),
		.o_sync    (pin_s)
	);

	assign drop_bus_clock_s  = pin_s[0];
	assign dbyte_s = pin_s[8:1];
	assign drop_parity_s  = pin_s[9];
	assign drop_payload_envelope_s  = pin_s[10];
	assign dmk_s   = pin_s[11];
	assign drop_signal_fail_s = pin_s[12];
	assign aclk_s  = pin_s[13];
	assign add_payload_envelope_s  = pin_s[14];
	assign amk_s   = pin_s[15];
	assign aen_s   = pin_s[16];
	assign cfg_s   = pin_s[17];

	logic       d_samp;
	logic       a_samp;
	logic       a_launch;
	logic [6:0] nslots;
	logic       d_xor;
	logic       d_perr;
	logic       a_par_calc;
	logic       apb_acc;
	logic       apb_wr;
	logic       hit;
	logic [9:0] ridx;

	assign nslots = cfg_s ? SLOTS_NARROW : SLOTS_WIDE;
	assign d_samp = q.drop_edge ? (!drop_bus_clock_s && q.drop_bus_clock_prev)
	                            : (drop_bus_clock_s && !q.drop_bus_clock_prev);
	assign a_samp   = q.add_edge ? (!aclk_s && q.aclk_prev)
	                             : (aclk_s && !q.aclk_prev);
	assign a_launch = q.add_edge ? (aclk_s && !q.aclk_prev)
	                             : (!aclk_s && q.aclk_prev);

	assign d_xor  = (^dbyte_s) ^ drop_parity_s
	                ^ (q.par_scope & (drop_payload_envelope_s ^ dmk_s));
	assign d_perr = q.par_pol ? d_xor : !d_xor;

	assign a_par_calc = !q.par_pol ^ (^i_add_data)
	                    ^ (q.par_scope & (q.add_payload_envelope ^ q.amk));

	assign apb_acc = i_psel && i_penable;
	assign ridx    = i_paddr[11:2];
	assign hit     = (i_paddr[1:0] == 2'h0)
	                 && (ridx == REG_PARITY_IDX || ridx == REG_EDGE_IDX
	                 || ridx == REG_STATUS_IDX || ridx == REG_SLOT_IDX);
	// writes land only on the edge where the master sees pready high
	assign apb_wr  = apb_acc && q.apb_rdy && i_pwrite;

	always_comb
	begin
		logic [31:0] rd;
		logic [6:0]  cur;
		logic [6:0]  off;
		logic        in_rng;
		logic        own;
		logic [7:0]  lb;
		logic        lp;
		logic        ld;
		rd     = 32'h0;
		cur    = 7'h00;
		off    = 7'h00;
		in_rng = 1'b0;
		own    = 1'b0;
		lb     = 8'h00;
		lp     = 1'b0;
		ld     = 1'b0;
		n      = q;

		unique case (ridx)
			REG_PARITY_IDX:
			begin
				rd[PAR_POL_BIT]   = q.par_pol;
				rd[PAR_SCOPE_BIT] = q.par_scope;
			end
			REG_EDGE_IDX:
			begin
				rd[ADD_DLY_BIT]   = q.add_dly;
				rd[DROP_EDGE_BIT] = q.drop_edge;
				rd[ADD_EDGE_BIT]  = q.add_edge;
			end
			REG_STATUS_IDX:
			begin
				rd[ST_PAR_ERR_BIT]            = q.par_err;
				rd[ST_FAIL_BIT]               = q.fail_seen;
				rd[ST_CFG_BIT]                = cfg_s;
				rd[ST_AIS_LSB +: NUM_TRIB]    = q.ais;
			end
			REG_SLOT_IDX:
			begin
				rd[SLOT_EN_LSB +: NUM_TRIB]   = q.trib_en;
				rd[SLOT_BASE_LSB +: 7]        = q.slot_base;
			end
			default:
				rd = 32'h0;
		endcase

		if (i_clk_en)
		begin
			// one wait state: pready is a flop, so it trails penable by one
			n.apb_rdy = apb_acc && !q.apb_rdy;
			if (apb_acc && !q.apb_rdy)
			begin
				n.rdata  = hit ? rd : 32'h0;
				n.slverr = !hit;
			end
			if (apb_wr && hit)
			begin
				if (ridx == REG_PARITY_IDX)
				begin
					n.par_pol   = i_pwdata[PAR_POL_BIT];
					n.par_scope = i_pwdata[PAR_SCOPE_BIT];
				end
				if (ridx == REG_EDGE_IDX)
				begin
					n.add_dly   = i_pwdata[ADD_DLY_BIT];
					n.drop_edge = i_pwdata[DROP_EDGE_BIT];
					n.add_edge  = i_pwdata[ADD_EDGE_BIT];
				end
				if (ridx == REG_STATUS_IDX)
				begin
					n.par_err   = q.par_err & !i_pwdata[ST_PAR_ERR_BIT];
					n.fail_seen = q.fail_seen & !i_pwdata[ST_FAIL_BIT];
				end
				if (ridx == REG_SLOT_IDX)
				begin
					n.trib_en   = i_pwdata[SLOT_EN_LSB +: NUM_TRIB];
					n.slot_base = i_pwdata[SLOT_BASE_LSB +: 7];
				end
			end

			n.drop_bus_clock_prev = drop_bus_clock_s;
			n.aclk_prev = aclk_s;
			n.dvalid    = 1'b0;

			// drop side: locate payload start, check parity, handle fail
			if (d_samp)
			begin
				if (d_perr && !drop_signal_fail_s)
					n.par_err = 1'b1;
				if (drop_payload_envelope_s)
				begin
					if (dmk_s || q.dslot == nslots - 7'd1)
						cur = 7'h00;
					else
						cur = q.dslot + 7'd1;
					n.dslot    = cur;
					n.dvalid   = 1'b1;
					n.dinvalid = drop_signal_fail_s;
					n.ddata    = drop_signal_fail_s ? AIS_BYTE : dbyte_s;
					off        = cur - q.slot_base;
					if (cur >= q.slot_base && off < 7'(NUM_TRIB))
						n.ais[off[2:0]] = drop_signal_fail_s;
					if (drop_signal_fail_s)
						n.fail_seen = 1'b1;
				end
			end

			// add side: capture timing, work out slot ownership
			if (a_samp)
			begin
				n.add_payload_envelope = add_payload_envelope_s;
				n.amk  = amk_s;
				n.aown = 1'b0;
				if (add_payload_envelope_s)
				begin
					if (amk_s || q.aslot == nslots - 7'd1)
						cur = 7'h00;
					else
						cur = q.aslot + 7'd1;
					n.aslot = cur;
					off     = cur - q.slot_base;
					in_rng  = cur >= q.slot_base
					          && off < 7'(NUM_TRIB);
					n.aown  = in_rng && q.trib_en[off[2:0]];
				end
			end

			// launch: the stage holds the undelayed byte for one period
			if (a_launch)
			begin
				own = q.aown && q.add_payload_envelope;
				lb  = q.add_dly ? q.st_byte : i_add_data;
				lp  = q.add_dly ? q.st_par : a_par_calc;
				ld  = q.add_dly ? q.st_drv : own;
				n.st_byte = i_add_data;
				n.st_par  = a_par_calc;
				n.st_drv  = own;
				n.obyte   = lb;
				n.opar    = lp;
				n.odrv    = ld && aen_s;
			end
			else if (!aen_s)
				n.odrv = 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_sys_rst)
		begin
			q           <= '0;
			q.trib_en   <= TRIB_EN_RST;
			q.slot_base <= SLOT_BASE_RST;
		end
		else
			q <= n;
	end

	assign o_prdata                  = q.rdata;
	assign o_pready                  = q.apb_rdy;
	assign o_pslverr                 = q.slverr;
	assign o_add_byte                = q.obyte;
	assign o_add_parity              = q.opar;
	assign o_add_byte_oe             = q.odrv;
	assign o_add_parity_oe           = q.odrv;
	assign o_add_present_indicator_n = !q.odrv;
	assign o_drop_valid              = q.dvalid;
	assign o_drop_data               = q.ddata;
	assign o_drop_slot               = q.dslot;
	assign o_drop_invalid            = q.dinvalid;
	assign o_trib_ais                = q.ais;
	assign o_add_slot                = q.aslot;

	property p_drop_rise;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(d_samp && !q.drop_edge) |-> (drop_bus_clock_s && !q.drop_bus_clock_prev);
	endproperty
	a_drop_rise: assert property (p_drop_rise)
		else $error("drop sample not on rising drop clock");

	property p_par_err_set;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(i_clk_en && d_samp && !drop_signal_fail_s
		 && (q.par_pol ? d_xor : !d_xor)) |=> q.par_err;
	endproperty
	a_par_err_set: assert property (p_par_err_set)
		else $error("drop parity mismatch not flagged");

	property p_par_scope;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(i_clk_en && d_samp && !drop_signal_fail_s && !q.par_pol && !q.par_scope
		 && ((^dbyte_s) ^ drop_parity_s) && !q.par_err) |=> !q.par_err;
	endproperty
	a_par_scope: assert property (p_par_scope)
		else $error("odd data-only parity wrongly flagged");

	property p_par_err_sticky;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(q.par_err && !apb_wr) |=> q.par_err;
	endproperty
	a_par_err_sticky: assert property (p_par_err_sticky)
		else $error("parity status lost without a clear");

	property p_fail_ais;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(i_clk_en && d_samp && drop_payload_envelope_s && drop_signal_fail_s)
		|=> (q.dvalid && q.dinvalid && q.ddata == AIS_BYTE);
	endproperty
	a_fail_ais: assert property (p_fail_ais)
		else $error("failed slot not replaced by AIS");

	property p_add_sample;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		a_samp |-> (q.add_edge ? q.aclk_prev : !q.aclk_prev)
		           && (aclk_s != q.aclk_prev);
	endproperty
	a_add_sample: assert property (p_add_sample)
		else $error("add sampling on wrong edge");

	property p_add_swap;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(a_launch && q.add_edge) |-> (aclk_s && !q.aclk_prev);
	endproperty
	a_add_swap: assert property (p_add_swap)
		else $error("swapped launch not on rising add clock");

	property p_delay;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(i_clk_en && a_launch && q.add_dly)
		|=> (o_add_byte == $past(q.st_byte)
		     && o_add_parity == $past(q.st_par));
	endproperty
	a_delay: assert property (p_delay)
		else $error("delayed add byte not one period late");

	property p_par_gen;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(i_clk_en && a_launch && !q.add_dly)
		|=> (o_add_parity == $past(a_par_calc));
	endproperty
	a_par_gen: assert property (p_par_gen)
		else $error("add parity not generated on launch");

	property p_oe_gate;
		@(posedge i_clk_sys) disable iff (i_sys_rst)
		(i_clk_en && !aen_s) |=> !o_add_byte_oe && o_add_present_indicator_n;
	endproperty
	a_oe_gate: assert property (p_oe_gate)
		else $error("add bus driven while enable low");

	c_par_err: cover property (@(posedge i_clk_sys) $rose(q.par_err));
	c_ais: cover property (@(posedge i_clk_sys) $rose(q.dinvalid));
	c_drive: cover property (@(posedge i_clk_sys) $rose(o_add_byte_oe));
	c_dly_drive: cover property (@(posedge i_clk_sys)
		q.add_dly && $rose(o_add_byte_oe));

endmodule

// ===== verification/sadb_sys_model.sv
`timescale 1ns/1ps

// framer-side model: makes both link clocks, drives the drop bus and
// samples the add bus on the edge after the block launches it
module sadb_sys_model
(
	// add bus as resolved on the wires
	input  wire logic [7:0] i_add_bus,
	input  wire logic       i_add_par,
	input  wire logic       i_add_present_n,
	// drop bus
	output logic            o_drop_clk,
	output logic      [7:0] o_drop_byte,
	output logic            o_drop_par,
	output logic            o_drop_env,
	output logic            o_drop_mk,
	output logic            o_drop_fail,
	// add timing
	output logic            o_add_clk,
	output logic            o_add_env,
	output logic            o_add_mk
);
	function automatic logic sm_par(logic [7:0] d, logic e, logic m,
		logic pol, logic scp);
		return ^d ^ (scp & (e ^ m)) ^ ~pol;
	endfunction

	initial
	begin
		{o_drop_clk, o_drop_byte, o_drop_par, o_drop_env} = '0;
		{o_drop_mk, o_drop_fail, o_add_clk, o_add_env, o_add_mk} = '0;
	end

	// one byte per call; clock stands low between calls, and released
	// pins show the inverse so a late sample cannot pass by luck
	// flags are {envelope, marker, fail, corrupt parity}
	task automatic drop_word(input logic [7:0] b, input logic [3:0] f,
		input logic pol, input logic scp);
		#16;
		{o_drop_byte, o_drop_env, o_drop_mk, o_drop_fail} = {b, f[3:1]};
		o_drop_par = sm_par(b, f[3], f[2], pol, scp) ^ f[0];
		#16 o_drop_clk = 1'b1;
		#32 o_drop_clk = 1'b0;
		#16;
		{o_drop_byte, o_drop_par, o_drop_env, o_drop_mk, o_drop_fail} =
			~{o_drop_byte, o_drop_par, o_drop_env, o_drop_mk, o_drop_fail};
	endtask

	// one add slot; envelope stays high for every slot of the frame
	task automatic add_slot(input logic m, input logic swap,
		output logic [7:0] b, output logic p, output logic n);
		#16;
		{o_add_env, o_add_mk} = {1'b1, m};
		#16 o_add_clk = 1'b1;
		if (!swap)
			{b, p, n} = {i_add_bus, i_add_par, i_add_present_n};
		#32 o_add_clk = 1'b0;
		if (swap)
			{b, p, n} = {i_add_bus, i_add_par, i_add_present_n};
	endtask
endmodule

// ===== verification/tb.sv
`timescale 1ns/1ps

module tb
	import sadb_pkg::*;
;
	localparam logic [11:0] A_PAR  = {REG_PARITY_IDX, 2'b00};
	localparam logic [11:0] A_EDGE = {REG_EDGE_IDX, 2'b00};
	localparam logic [11:0] A_ST   = {REG_STATUS_IDX, 2'b00};
	localparam logic [11:0] A_SLOT = {REG_SLOT_IDX, 2'b00};

	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic        cfg = 1'b0;
	logic        gate = 1'b1;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [7:0]  add_data = 8'h3A;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	wire         drop_bus_clock, drop_parity, denv, dmk, drop_signal_fail, aclk, aenv, amk;
	wire  [7:0]  db;
	logic [7:0]  ab, dd, last_d;
	logic        abo, ap, apo, apn, dv, dinv, last_inv;
	logic [6:0]  ds, ais, last_s;
	int          fail_count = 0;
	int          n_tests = 0;
	int          n_drop = 0;

	// undriven wires float so the model sees a released bus as z
	wire  [7:0]  add_bus = abo ? ab : 8'hZZ;
	wire         add_par_w = apo ? ap : 1'bz;

	always #2.5 clk = ~clk;

	sadb_port dut_u
	(
		.i_clk_sys(clk), .i_sys_rst(rst), .i_clk_en(1'b1),
		.i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr),
		.i_bus_config_pin(cfg), .i_drop_bus_clock(drop_bus_clock),
		.i_drop_byte(db), .i_drop_parity(drop_parity),
		.i_drop_payload_envelope(denv), .i_drop_frame_marker(dmk),
		.i_drop_signal_fail(drop_signal_fail), .i_add_bus_clock(aclk),
		.i_add_payload_envelope(aenv), .i_add_frame_marker(amk),
		.i_add_output_enable(aenv & gate), .o_add_byte(ab),
		.o_add_byte_oe(abo), .o_add_parity(ap), .o_add_parity_oe(apo),
		.o_add_present_indicator_n(apn), .o_drop_valid(dv),
		.o_drop_data(dd), .o_drop_slot(ds), .o_drop_invalid(dinv),
		.o_trib_ais(ais), .i_add_data(add_data), .o_add_slot()
	);

	sadb_sys_model sys_u
	(
		.i_add_bus(add_bus), .i_add_par(add_par_w),
		.i_add_present_n(apn), .o_drop_clk(drop_bus_clock), .o_drop_byte(db),
		.o_drop_par(drop_parity), .o_drop_env(denv), .o_drop_mk(dmk),
		.o_drop_fail(drop_signal_fail), .o_add_clk(aclk), .o_add_env(aenv),
		.o_add_mk(amk)
	);

	always @(posedge clk)
		if (dv === 1'b1)
		begin
			n_drop++;
			{last_s, last_inv, last_d} = {ds, dinv, dd};
		end

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// request held from setup until pready is seen high at an edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int i;
		@(posedge clk);
		{psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge clk);
		pen <= 1'b1;
		for (i = 0; i < 40 && pready !== 1'b1; i++)
			@(posedge clk);
		if (i == 40)
		begin
			fail_count++;
			$display("[FAIL] t=%0t apb timeout", $time);
			wrap_up;
		end
		{r, e} = {prdata, pslverr};
		{psel, pen} <= 2'b00;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] x,
		input logic xe);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, x);
		chk(32'(e), 32'(xe));
	endtask

	task automatic s_regs;
		rdchk(A_PAR, 32'h0, 1'b0);
		rdchk(A_EDGE, 32'h0, 1'b0);
		rdchk(A_ST, 32'h0, 1'b0);
		rdchk(A_SLOT, 32'h0, 1'b0);
		rdchk(12'h3F0, 32'h0, 1'b1);
		rdchk(A_SLOT + 12'h1, 32'h0, 1'b1);
		wr(A_SLOT, 32'h0000_7F7F);
		rdchk(A_SLOT, 32'h0000_7F7F, 1'b0);
		cfg <= 1'b1;
		repeat (4) @(posedge clk);
		rdchk(A_ST, 32'h4, 1'b0);
		cfg <= 1'b0;
		repeat (4) @(posedge clk);
		rdchk(A_ST, 32'h0, 1'b0);
	endtask

	// every parity polarity and scope; a wrong setting flags good bytes
	task automatic s_drop;
		int   c, n0;
		logic p, s;
		for (c = 0; c < 4; c++)
		begin
			{s, p} = c[1:0];
			wr(A_PAR, {28'h0, s, p, 2'b00});
			wr(A_ST, 32'h3);
			n0 = n_drop;
			sys_u.drop_word(8'h5A, 4'b1100, p, s);
			chk(32'({last_s, last_d}), 32'h005A);
			sys_u.drop_word(8'h81, 4'b1000, p, s);
			chk(32'({last_s, last_d}), 32'h0181);
			sys_u.drop_word(8'hC3, 4'b0000, p, s);
			chk(n_drop - n0, 32'd2);
			rdchk(A_ST, 32'h0, 1'b0);
			sys_u.drop_word(8'h07, 4'b1001, p, s);
			rdchk(A_ST, 32'h1, 1'b0);
			wr(A_ST, 32'h1);
			rdchk(A_ST, 32'h0, 1'b0);
		end
	endtask

	// tributary 0 sits in slot 1; its bad parity must not be flagged
	task automatic s_fail;
		wr(A_SLOT, 32'h0101);
		wr(A_ST, 32'h3);
		sys_u.drop_word(8'h11, 4'b1100, 1'b1, 1'b1);
		sys_u.drop_word(8'h42, 4'b1011, 1'b1, 1'b1);
		chk(32'({ais, last_inv, last_d}), 32'h3FF);
		rdchk(A_ST, 32'h0102, 1'b0);
		sys_u.drop_word(8'h11, 4'b1100, 1'b1, 1'b1);
		sys_u.drop_word(8'h42, 4'b1000, 1'b1, 1'b1);
		chk(32'({ais, last_inv, last_d}), 32'h042);
	endtask

	// owned slot 2 is seen one slot later, two with the delay bit;
	// the last pass holds the output enable low
	task automatic s_add;
		int          m, i;
		logic [7:0]  b;
		logic        p, n, e, d;
		logic [31:0] x;
		wr(A_SLOT, 32'h0201);
		for (m = 0; m < 5; m++)
		begin
			{d, e} = m[1:0];
			gate <= (m < 4);
			wr(A_EDGE, {26'h0, e, 1'b0, d, 3'b000});
			wr(A_PAR, {28'h0, d, e, 2'b00});
			x = 32'({add_data, sys_u.sm_par(add_data, 1'b1, 1'b0, e, d),
				1'b0});
			for (i = 0; i < 6; i++)
			begin
				sys_u.add_slot(i == 0, e, b, p, n);
				if (i > 0 && i == 3 + d && m < 4)
					chk(32'({b, p, n}), x);
				else if (i > 0)
					chk(32'({b, p, n}), 32'({8'hZZ, 1'bz, 1'b1}));
			end
		end
	endtask

	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		s_regs;
		s_drop;
		s_fail;
		s_add;
		wrap_up;
	end

	initial
	begin
		#200000;
		fail_count++;
		$display("[FAIL] t=%0t run timeout", $time);
		wrap_up;
	end
endmodule
